// ---- core/sgss_params.svh ----
// Constants for the servo gain set switching block
`ifndef SGSS_PARAMS_SVH
`define SGSS_PARAMS_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define SGSS_OFF_CTRL    8'h00
`define SGSS_OFF_MFSW    8'h04
`define SGSS_OFF_FFGAIN  8'h08
`define SGSS_OFF_WAIT    8'h0c
`define SGSS_OFF_SWTIME  8'h10
`define SGSS_OFF_STATUS  8'h14
`define SGSS_OFF_VIB1    8'h18
`define SGSS_BANK_PAGE   2'h1

// ****************************************************
// Field positions and codes
// ****************************************************
`define SGSS_MODE_LSB    0
`define SGSS_FFEN_BIT    2
`define SGSS_MODE_MANUAL 2'h0
`define SGSS_MODE_AUTO   2'h2
`define SGSS_MFSW_D3_LSB 12
`define SGSS_MFSW_D0_LSB 0
`define SGSS_D3_COMBINE  4'h1

// ****************************************************
// Parameter bank entries
// ****************************************************
`define SGSS_SET_LEN     7
`define SGSS_IDX_POS     2
`define SGSS_IDX_MFG     4
`define SGSS_IDX_MFC     5
`define SGSS_IDX_VIB2F   4'he
`define SGSS_IDX_VIB2C   4'hf

// ****************************************************
// Reset values
// ****************************************************
`define SGSS_RST_CTRL    3'h0
`define SGSS_RST_MFSW    16'h0000
`define SGSS_RST_FFGAIN  16'h0000
`define SGSS_RST_WAIT    32'h0000_0000
`define SGSS_RST_SWTIME  32'h0000_0000
`define SGSS_RST_VIB1    32'h01f8_01f8
`define SGSS_RST_SPG     16'h0190
`define SGSS_RST_SPI     16'h07d0
`define SGSS_RST_POS     16'h0190
`define SGSS_RST_TRQF    16'h0064
`define SGSS_RST_MFG     16'h01f4
`define SGSS_RST_MFC     16'h03e8
`define SGSS_RST_FRC     16'h0064
`define SGSS_RST_VIB2    16'h0064

// ****************************************************
// Timing
// ****************************************************
`define SGSS_DIV_STEPS   5'h10

`endif

// ---- core/sgss_pkg.sv ----
// Types for the servo gain set switching block
`default_nettype none
package sgss_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DIV, ST_RAMP} sgss_state_t;
  typedef logic [15:0] sgss_word_t;
endpackage : sgss_pkg
`default_nettype wire

// ---- core/sgss_param_bank.sv ----
// Sixteen-word gain parameter bank with registered read port
`timescale 1ns/100ps
`default_nettype none
`include "sgss_params.svh"
module sgss_param_bank
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Write port
  input  wire logic         we,
  input  wire logic [3:0]   waddr,
  input  wire logic [15:0]  wdata,
  // Read port
  input  wire logic [3:0]   raddr,
  output var  logic [15:0]  rdata,
  // All entries in parallel
  output var  logic [255:0] words
);

  function automatic logic [15:0] rst_val(input int idx);
    logic [15:0] v;
    v = `SGSS_RST_VIB2;
    if (idx < 2 * `SGSS_SET_LEN)
    begin
      case (idx % `SGSS_SET_LEN)
        0:       v = `SGSS_RST_SPG;
        1:       v = `SGSS_RST_SPI;
        2:       v = `SGSS_RST_POS;
        3:       v = `SGSS_RST_TRQF;
        4:       v = `SGSS_RST_MFG;
        5:       v = `SGSS_RST_MFC;
        default: v = `SGSS_RST_FRC;
      endcase
    end
    return v;
  endfunction : rst_val

  // ****************************************************
  // Storage, one flop word per entry
  // ****************************************************
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_word
      localparam logic [15:0] rst_word = rst_val(g);
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          words[g*16 +: 16] <= rst_word;
        else if (we && (waddr == 4'(g)))
          words[g*16 +: 16] <= wdata;
      end
    end
  endgenerate

  // Registered read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 16'h0000;
    else
      rdata <= words[raddr*16 +: 16];
  end

endmodule : sgss_param_bank
`default_nettype wire

// ---- core/sgss_top.sv ----
// Gain set selection, ramp and feedforward gating with APB registers
//
// Function
// [R1] Feedforward gain and inputs disabled after reset
// [R2] Digit 3 of switch set combines feedforward
// [R3] Host avoids feedforward during model following
// [R4] Switch writable during tuning, updated after
// [R5] Vibration 1 frequencies frozen, then updated
// [R6] Vibration 2 parameters frozen, never auto-updated
// [R7] Select field: 0 manual, 2 auto
// [R8] Manual follows select bit; auto self-switches
// [R9] Each set supplies all seven gains
// [R10] Model following gains switch in manual only
// [R11] Model following switches when idle and stopped
// [R12] Otherwise other gains switch, model following held
// [R13] Host picks high gains positioning, low stopped
// [R14] Select bit 0 set 1, 1 set 2
// [R15] Automatic switching only under position control
// [R16] Wait, then ramp position gain linearly
// [R17] Active set registered, resets to set 1
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "sgss_params.svh"
module sgss_top
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Command network and motion state
  input  wire logic        g_sel,
  input  wire logic        cmd_busy,
  input  wire logic        motor_stopped,
  input  wire logic        position_mode,
  input  wire logic        cond_a,
  input  wire logic [15:0] speed_ff_input,
  input  wire logic [15:0] torque_ff_input,
  // Vibration suppression tuner
  input  wire logic        tune_active,
  input  wire logic        tune_done,
  input  wire logic [15:0] tune_freq_a,
  input  wire logic [15:0] tune_freq_b,
  input  wire logic [15:0] tune_mf_sw,
  // Loop parameters out
  output var  logic [15:0] speed_loop_gain,
  output var  logic [15:0] speed_integral,
  output var  logic [15:0] position_loop_gain,
  output var  logic [15:0] torque_filter,
  output var  logic [15:0] mf_gain,
  output var  logic [15:0] mf_gain_comp,
  output var  logic [15:0] friction_comp,
  output var  logic [15:0] feedforward_gain,
  output var  logic [15:0] speed_ff_out,
  output var  logic [15:0] torque_ff_out,
  output var  logic [31:0] vib1_freq,
  output var  logic        active_set,
  output var  logic        mf_set
);

  // ****************************************************
  // Registers and decode
  // ****************************************************
  logic [2:0]          ctrl_q;
  logic [15:0]         mfsw_q;
  logic [15:0]         ffgain_q;
  logic [31:0]         wait_q;
  logic [31:0]         swtime_q;
  logic [31:0]         vib1_q;
  logic [31:0]         rd_q;
  logic                bank_rd_q;
  logic [15:0]         bank_rdata;
  logic [255:0]        bank_words;
  logic                set_q;
  logic                mf_set_q;
  logic                gsel_q;
  sgss_pkg::sgss_state_t state_q;
  logic                target_q;
  logic [15:0]         cnt_q;
  logic [15:0]         tlen_q;
  logic [16:0]         rem_q;
  logic [15:0]         quo_q;
  logic [4:0]          div_q;
  logic [16:0]         acc_q;
  logic [15:0]         ramp_q;
  logic                up_q;
  logic                is_bank, is_known, wr_acc, wr_block, wr_ok;
  logic [3:0]          bidx;
  logic [1:0]          mode;
  logic                manual, auto_on, target;
  logic                mf_active, ff_allow;
  logic [15:0]         pos_old, pos_new;
  logic [16:0]         rem_sh, acc_n;

  assign is_bank  = paddr[7:6] == `SGSS_BANK_PAGE;
  assign bidx     = paddr[5:2];
  assign is_known = is_bank || paddr == `SGSS_OFF_CTRL ||
                    paddr == `SGSS_OFF_MFSW || paddr == `SGSS_OFF_FFGAIN ||
                    paddr == `SGSS_OFF_WAIT || paddr == `SGSS_OFF_SWTIME ||
                    paddr == `SGSS_OFF_STATUS || paddr == `SGSS_OFF_VIB1;
  assign wr_acc   = psel && penable && pwrite;
  // [R5] [R6] Frozen while tuning
  assign wr_block = tune_active && (paddr == `SGSS_OFF_VIB1 ||
                    (is_bank && (bidx == `SGSS_IDX_VIB2F ||
                     bidx == `SGSS_IDX_VIB2C ||
                     bidx == 4'(`SGSS_IDX_MFG) || bidx == 4'(`SGSS_IDX_MFC) ||
                     bidx == 4'(`SGSS_IDX_MFG + `SGSS_SET_LEN) ||
                     bidx == 4'(`SGSS_IDX_MFC + `SGSS_SET_LEN))));
  assign wr_ok    = wr_acc && is_known && !wr_block &&
                    paddr != `SGSS_OFF_STATUS;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && (!is_known || (pwrite &&
                    (wr_block || paddr == `SGSS_OFF_STATUS)));
  assign prdata   = bank_rd_q ? {16'h0000, bank_rdata} : rd_q;

  sgss_param_bank u_bank
  (
    .clk   (pclk),
    .rst_n (presetn),
    .we    (wr_ok && is_bank),
    .waddr (bidx),
    .wdata (pwdata[15:0]),
    .raddr (bidx),
    .rdata (bank_rdata),
    .words (bank_words)
  );

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_q      <= 32'h0000_0000;
      bank_rd_q <= 1'b0;
    end
    else if (psel && !penable)
    begin
      bank_rd_q <= is_bank;
      case (paddr)
        `SGSS_OFF_CTRL:   rd_q <= {29'h0, ctrl_q};
        `SGSS_OFF_MFSW:   rd_q <= {16'h0, mfsw_q};
        `SGSS_OFF_FFGAIN: rd_q <= {16'h0, ffgain_q};
        `SGSS_OFF_WAIT:   rd_q <= wait_q;
        `SGSS_OFF_SWTIME: rd_q <= swtime_q;
        `SGSS_OFF_STATUS: rd_q <= {26'h0, state_q, tune_active,
                                   state_q != sgss_pkg::ST_IDLE,
                                   mf_set_q, set_q};
        `SGSS_OFF_VIB1:   rd_q <= vib1_q;
        default:          rd_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************
  // Configuration registers
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q   <= `SGSS_RST_CTRL;
      ffgain_q <= `SGSS_RST_FFGAIN;
      wait_q   <= `SGSS_RST_WAIT;
      swtime_q <= `SGSS_RST_SWTIME;
    end
    else if (wr_ok)
    begin
      // [R7] New select takes effect at once
      if (paddr == `SGSS_OFF_CTRL)
        ctrl_q <= pwdata[2:0];
      if (paddr == `SGSS_OFF_FFGAIN)
        ffgain_q <= pwdata[15:0];
      if (paddr == `SGSS_OFF_WAIT)
        wait_q <= pwdata;
      if (paddr == `SGSS_OFF_SWTIME)
        swtime_q <= pwdata;
    end
  end

  // [R4] Tuner result wins over a write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mfsw_q <= `SGSS_RST_MFSW;
    else if (tune_done)
      mfsw_q <= tune_mf_sw;
    else if (wr_ok && paddr == `SGSS_OFF_MFSW)
      mfsw_q <= pwdata[15:0];
  end

  // [R5] Frequencies loaded when tuning ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vib1_q <= `SGSS_RST_VIB1;
    else if (tune_done)
      vib1_q <= {tune_freq_b, tune_freq_a};
    else if (wr_ok && paddr == `SGSS_OFF_VIB1)
      vib1_q <= pwdata;
  end

  // ****************************************************
  // Set selection
  // ****************************************************
  assign mode    = ctrl_q[`SGSS_MODE_LSB +: 2];
  assign manual  = mode != `SGSS_MODE_AUTO;
  assign auto_on = !manual && position_mode;
  assign target  = cond_a;
  assign pos_old = bank_words[(set_q ? 7 + `SGSS_IDX_POS
                              : `SGSS_IDX_POS)*16 +: 16];
  assign pos_new = bank_words[(target_q ? 7 + `SGSS_IDX_POS
                              : `SGSS_IDX_POS)*16 +: 16];

  // [R17] Active set register, set 1 at reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      set_q <= 1'b0;
    // [R8] [R14] Manual follows the select bit
    else if (manual)
      set_q <= g_sel;
    // [R15] Fixed set outside position control
    else if (!position_mode)
      set_q <= 1'b0;
    else if (state_q == sgss_pkg::ST_WAIT && cnt_q == 16'h0000 &&
             target == target_q)
      set_q <= target_q;
  end

  // [R10] [R11] [R12] Held unless the select bit changes in manual while idle and stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mf_set_q <= 1'b0;
      gsel_q   <= 1'b0;
    end
    else
    begin
      gsel_q <= g_sel;
      if (manual && g_sel != gsel_q && !cmd_busy && motor_stopped)
        mf_set_q <= g_sel;
    end
  end

  // [R16] Wait, divide, then linear ramp
  assign rem_sh = {rem_q[15:0], quo_q[15]};
  assign acc_n  = acc_q + rem_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q  <= sgss_pkg::ST_IDLE;
      target_q <= 1'b0;
      cnt_q    <= 16'h0000;
      tlen_q   <= 16'h0000;
      rem_q    <= 17'h00000;
      quo_q    <= 16'h0000;
      div_q    <= 5'h00;
      acc_q    <= 17'h00000;
      ramp_q   <= 16'h0000;
      up_q     <= 1'b0;
    end
    else if (!auto_on)
      state_q <= sgss_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        sgss_pkg::ST_IDLE:
          if (target != set_q)
          begin
            target_q <= target;
            cnt_q    <= target ? wait_q[15:0] : wait_q[31:16];
            tlen_q   <= target ? swtime_q[15:0] : swtime_q[31:16];
            state_q  <= sgss_pkg::ST_WAIT;
          end
        sgss_pkg::ST_WAIT:
          if (target != target_q)
            state_q <= sgss_pkg::ST_IDLE;
          else if (cnt_q != 16'h0000)
            cnt_q <= cnt_q - 16'h0001;
          else
          begin
            ramp_q  <= pos_old;
            up_q    <= pos_new >= pos_old;
            quo_q   <= (pos_new >= pos_old) ? pos_new - pos_old
                                           : pos_old - pos_new;
            rem_q   <= 17'h00000;
            acc_q   <= 17'h00000;
            div_q   <= `SGSS_DIV_STEPS;
            cnt_q   <= tlen_q;
            state_q <= (tlen_q == 16'h0000) ? sgss_pkg::ST_IDLE
                                            : sgss_pkg::ST_DIV;
          end
        sgss_pkg::ST_DIV:
          if (div_q != 5'h00)
          begin
            div_q <= div_q - 5'h01;
            if (rem_sh >= {1'b0, tlen_q})
            begin
              rem_q <= rem_sh - {1'b0, tlen_q};
              quo_q <= {quo_q[14:0], 1'b1};
            end
            else
            begin
              rem_q <= rem_sh;
              quo_q <= {quo_q[14:0], 1'b0};
            end
          end
          else
            state_q <= sgss_pkg::ST_RAMP;
        sgss_pkg::ST_RAMP:
        begin
          cnt_q <= cnt_q - 16'h0001;
          if (acc_n >= {1'b0, tlen_q})
          begin
            acc_q  <= acc_n - {1'b0, tlen_q};
            ramp_q <= up_q ? ramp_q + quo_q + 16'h0001
                           : ramp_q - quo_q - 16'h0001;
          end
          else
          begin
            acc_q  <= acc_n;
            ramp_q <= up_q ? ramp_q + quo_q : ramp_q - quo_q;
          end
          if (cnt_q == 16'h0001)
            state_q <= sgss_pkg::ST_IDLE;
        end
        default:
          state_q <= sgss_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // [R1] [R2] Feedforward gated by enable and digit 3
  assign mf_active = mfsw_q[`SGSS_MFSW_D0_LSB +: 4] != 4'h0;
  assign ff_allow  = ctrl_q[`SGSS_FFEN_BIT] && (!mf_active ||
                     mfsw_q[`SGSS_MFSW_D3_LSB +: 4] == `SGSS_D3_COMBINE);

  // [R9] Gains from the active set, position gain from the ramp while ramping, model following pair from the mf set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      speed_loop_gain    <= `SGSS_RST_SPG;
      speed_integral     <= `SGSS_RST_SPI;
      position_loop_gain <= `SGSS_RST_POS;
      torque_filter      <= `SGSS_RST_TRQF;
      friction_comp      <= `SGSS_RST_FRC;
      mf_gain            <= `SGSS_RST_MFG;
      mf_gain_comp       <= `SGSS_RST_MFC;
      speed_ff_out       <= 16'h0000;
      torque_ff_out      <= 16'h0000;
    end
    else
    begin
      speed_loop_gain    <= bank_words[(set_q ? 7 : 0)*16 +: 16];
      speed_integral     <= bank_words[(set_q ? 8 : 1)*16 +: 16];
      position_loop_gain <= (state_q == sgss_pkg::ST_DIV ||
                             state_q == sgss_pkg::ST_RAMP) ? ramp_q
                                                           : pos_old;
      torque_filter      <= bank_words[(set_q ? 10 : 3)*16 +: 16];
      friction_comp      <= bank_words[(set_q ? 13 : 6)*16 +: 16];
      mf_gain            <= bank_words[(mf_set_q ? 11 : 4)*16 +: 16];
      mf_gain_comp       <= bank_words[(mf_set_q ? 12 : 5)*16 +: 16];
      speed_ff_out       <= ff_allow ? speed_ff_input : 16'h0000;
      torque_ff_out      <= ff_allow ? torque_ff_input : 16'h0000;
    end
  end

  assign feedforward_gain = ffgain_q;
  assign vib1_freq        = vib1_q;
  assign active_set       = set_q;
  assign mf_set           = mf_set_q;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ff_off;
    !ctrl_q[`SGSS_FFEN_BIT] |=> speed_ff_out == 16'h0000 &&
                                torque_ff_out == 16'h0000;
  endproperty
  a_ff_off: assert property (p_ff_off) // [R1]
    else $error("feedforward passed while disabled");

  property p_ff_combine;
    mf_active && mfsw_q[15:12] != 4'h1 |=> torque_ff_out == 16'h0000;
  endproperty
  a_ff_combine: assert property (p_ff_combine) // [R2]
    else $error("feedforward combined with model following");

  property p_mfsw_tune;
    tune_active && !tune_done && wr_acc && paddr == `SGSS_OFF_MFSW
      |=> mfsw_q == $past(pwdata[15:0]);
  endproperty
  a_mfsw_tune: assert property (p_mfsw_tune) // [R4]
    else $error("switch write lost during tuning");

  property p_vib1;
    tune_done |=> vib1_q == $past({tune_freq_b, tune_freq_a}) ##1
                  (!tune_active || $stable(vib1_q));
  endproperty
  a_vib1: assert property (p_vib1) // [R5]
    else $error("vibration 1 frequencies wrong");

  property p_vib2;
    tune_active && psel && penable && pwrite && is_bank &&
      bidx == `SGSS_IDX_VIB2F |-> pslverr;
  endproperty
  a_vib2: assert property (p_vib2) // [R6]
    else $error("vibration 2 write accepted during tuning");

  property p_manual;
    manual ##1 manual |-> set_q == $past(g_sel);
  endproperty
  a_manual: assert property (p_manual) // [R14]
    else $error("active set does not follow select bit");

  property p_mf_auto;
    !manual |=> $stable(mf_set_q);
  endproperty
  a_mf_auto: assert property (p_mf_auto) // [R10]
    else $error("model following set moved in auto mode");

  property p_mf_hold;
    manual && g_sel != gsel_q && (cmd_busy || !motor_stopped)
      |=> $stable(mf_set_q) && set_q == $past(g_sel);
  endproperty
  a_mf_hold: assert property (p_mf_hold) // [R12]
    else $error("model following switched while not idle");

  property p_nonpos;
    !manual && !position_mode |=> !set_q;
  endproperty
  a_nonpos: assert property (p_nonpos) // [R15]
    else $error("set moved outside position control");

  property p_ramp_end;
    state_q == sgss_pkg::ST_RAMP && cnt_q == 16'h0001 && auto_on
      |=> ramp_q == pos_old;
  endproperty
  a_ramp_end: assert property (p_ramp_end) // [R16]
    else $error("ramp did not end on new gain");

endmodule : sgss_top
`default_nettype wire

// ---- test/sgss_host_model.sv ----
// Host motion controller model for the command network side
`timescale 1ns/100ps
`default_nettype none
module sgss_host_model
(
  // Clock
  input  wire logic        clk,
  // Command network
  output var  logic        g_sel,
  output var  logic        cmd_busy,
  output var  logic        motor_stopped,
  output var  logic        position_mode,
  output var  logic        cond_a,
  output var  logic [15:0] speed_ff_input,
  output var  logic [15:0] torque_ff_input
);
  initial
  begin
    g_sel = 1'h0;
    cmd_busy = 1'h0;
    motor_stopped = 1'h1;
    position_mode = 1'h0;
    cond_a = 1'h0;
    speed_ff_input = 16'h0000;
    torque_ff_input = 16'h0000;
  end
  task automatic cmd(input logic sel, input logic busy, input logic stop);
    @(posedge clk);
    g_sel <= sel;
    cmd_busy <= busy;
    motor_stopped <= stop;
  endtask : cmd
  task automatic motion(input logic pos, input logic cond);
    @(posedge clk);
    position_mode <= pos;
    cond_a <= cond;
  endtask : motion
  task automatic feed(input logic [15:0] s, input logic [15:0] t);
    @(posedge clk);
    speed_ff_input <= s;
    torque_ff_input <= t;
  endtask : feed
endmodule : sgss_host_model
`default_nettype wire

// ---- test/sgss_top_test.sv ----
// Self-checking bench for the gain set switching block
`timescale 1ns/100ps
`default_nettype none
`include "sgss_params.svh"
`define CHK(nm, e, g) check_val(nm, 32'(e), 32'(g))
module sgss_top_test;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, tune_active = 1'h0, tune_done = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, vib1_freq;
  logic [15:0] tfa = 16'h0, tfb = 16'h0, tmf = 16'h0;
  logic pready, pslverr, g_sel, busy, stopped, posm, cond, aset, mset;
  logic [15:0] sffi, tffi, spg, spi, posg, trqf, mfg, mfc, frc, ffg, sfo, tfo;
  logic [15:0] gv [7];
  int err_count = 0, num_checks = 0, cyc = 0;
  localparam logic [15:0] DFLT [7] = '{`SGSS_RST_SPG, `SGSS_RST_SPI,
    `SGSS_RST_POS, `SGSS_RST_TRQF, `SGSS_RST_MFG, `SGSS_RST_MFC, `SGSS_RST_FRC};
  always #12.5 pclk = ~pclk;
  always_comb gv = '{spg, spi, posg, trqf, mfg, mfc, frc};
  sgss_host_model host (.clk(pclk), .g_sel(g_sel), .cmd_busy(busy),
    .motor_stopped(stopped), .position_mode(posm), .cond_a(cond),
    .speed_ff_input(sffi), .torque_ff_input(tffi));
  sgss_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .g_sel(g_sel), .cmd_busy(busy),
    .motor_stopped(stopped), .position_mode(posm), .cond_a(cond),
    .speed_ff_input(sffi), .torque_ff_input(tffi), .tune_active(tune_active),
    .tune_done(tune_done), .tune_freq_a(tfa), .tune_freq_b(tfb),
    .tune_mf_sw(tmf), .speed_loop_gain(spg), .speed_integral(spi),
    .position_loop_gain(posg), .torque_filter(trqf), .mf_gain(mfg),
    .mf_gain_comp(mfc), .friction_comp(frc), .feedforward_gain(ffg),
    .speed_ff_out(sfo), .torque_ff_out(tfo), .vib1_freq(vib1_freq),
    .active_set(aset), .mf_set(mset));
  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic check_val(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic x;
    apb(1'h1, a, d, r, x);
    `CHK("write error", e, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    logic x;
    apb(1'h0, a, 32'h0, r, x);
    `CHK("read error", 1'h0, x);
    `CHK("read data", e, r);
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle
  task automatic chk_gains(input logic [6:0] s2);
    for (int i = 0; i < 7; i++)
      `CHK("gain", s2[i] ? 16'(16'h1007 + i) : DFLT[i], gv[i]);
  endtask : chk_gains
  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_reset();
    host.feed(16'h0123, 16'h0456);
    settle();
    `CHK("ff gain", 16'h0, ffg);
    `CHK("speed ff", 16'h0, sfo);
    `CHK("torque ff", 16'h0, tfo);
    `CHK("active set", 1'h0, aset);
    chk_gains(7'h00);
  endtask : t_reset
  task automatic t_ffgate();
    wr(`SGSS_OFF_CTRL, 32'h4, 1'h0);
    wr(`SGSS_OFF_MFSW, 32'h0001, 1'h0);
    settle();
    `CHK("speed ff", 16'h0, sfo);
    `CHK("torque ff", 16'h0, tfo);
    wr(`SGSS_OFF_MFSW, 32'h1001, 1'h0);
    settle();
    `CHK("speed ff", 16'h0123, sfo);
    `CHK("torque ff", 16'h0456, tfo);
    wr(`SGSS_OFF_CTRL, 32'h0, 1'h0);
  endtask : t_ffgate
  task automatic t_manual();
    for (int i = 7; i < 14; i++)
      wr(8'(8'h40 + 4 * i), 32'(16'h1000 + i), 1'h0);
    host.cmd(1'h1, 1'h0, 1'h1);
    settle();
    `CHK("active set", 1'h1, aset);
    `CHK("mf set", 1'h1, mset);
    chk_gains(7'h7f);
    host.cmd(1'h0, 1'h1, 1'h1);
    settle();
    `CHK("active set", 1'h0, aset);
    `CHK("mf set", 1'h1, mset);
    chk_gains(7'h30);
    host.cmd(1'h1, 1'h0, 1'h1);
    host.cmd(1'h0, 1'h0, 1'h1);
    settle();
    `CHK("mf set", 1'h0, mset);
    host.cmd(1'h1, 1'h0, 1'h0);
    settle();
    `CHK("mf set", 1'h0, mset);
    `CHK("active set", 1'h1, aset);
    host.cmd(1'h0, 1'h0, 1'h1);
  endtask : t_manual
  task automatic t_auto();
    int n;
    wr(`SGSS_OFF_CTRL, 32'(`SGSS_MODE_AUTO), 1'h0);
    wr(`SGSS_OFF_WAIT, 32'h0003_0002, 1'h0);
    wr(`SGSS_OFF_SWTIME, 32'h0004_0004, 1'h0);
    host.motion(1'h1, 1'h0);
    host.cmd(1'h1, 1'h0, 1'h1);
    settle();
    `CHK("active set", 1'h0, aset);
    `CHK("mf set", 1'h0, mset);
    host.motion(1'h1, 1'h1);
    n = 0;
    while (posg !== 16'h1009 && n < 200)
    begin
      @(posedge pclk);
      #1;
      n++;
      if (n == 3 || n == 4)
        `CHK("wait end", n == 4, aset);
      if (n == 24)
        `CHK("ramp mid", 16'h08cc, posg);
    end
    `CHK("switch cycles", 26, n);
    `CHK("active set", 1'h1, aset);
    `CHK("pos gain", 16'h1009, posg);
    chk_gains(7'h4f);
    host.motion(1'h0, 1'h1);
    repeat (40) @(posedge pclk);
    #1;
    `CHK("active set", 1'h0, aset);
    wr(`SGSS_OFF_CTRL, 32'h0, 1'h0);
    host.cmd(1'h0, 1'h0, 1'h1);
  endtask : t_auto
  task automatic t_tune();
    @(posedge pclk);
    tune_active <= 1'h1;
    wr(`SGSS_OFF_VIB1, 32'h0, 1'h1);
    wr(8'h78, 32'h0, 1'h1);
    wr(`SGSS_OFF_MFSW, 32'h2, 1'h0);
    rd(`SGSS_OFF_MFSW, 32'h2);
    `CHK("vib1", `SGSS_RST_VIB1, vib1_freq);
    tfa <= 16'h0111;
    tfb <= 16'h0222;
    tmf <= 16'h0003;
    tune_done <= 1'h1;
    tune_active <= 1'h0;
    @(posedge pclk);
    tune_done <= 1'h0;
    settle();
    `CHK("vib1", 32'h0222_0111, vib1_freq);
    rd(`SGSS_OFF_MFSW, 32'h3);
    rd(8'h78, 32'(`SGSS_RST_VIB2));
    wr(8'h30, 32'h0, 1'h1);
    wr(`SGSS_OFF_STATUS, 32'h0, 1'h1);
  endtask : t_tune
  // ****************************************************
  // Main sequence and timeout
  // ****************************************************
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_ffgate();
    t_manual();
    t_auto();
    t_tune();
    print_verdict();
  end
endmodule : sgss_top_test
`default_nettype wire
